// ### core/scrb_pkg.sv
// Constants, types and helpers shared by both ends of the secondary
// configuration bank link. Assumes a 10 MHz pclk on both ends.
package scrb_pkg;

  // ----------------------------------------------------------------
  // Bank offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_TUNE0 = 5'h00;
  localparam logic [4:0] OFF_TUNE1 = 5'h01;
  localparam logic [4:0] OFF_TUNE2 = 5'h02;
  localparam logic [4:0] OFF_TUNE3 = 5'h03;
  localparam logic [4:0] OFF_RADIO = 5'h04;
  localparam logic [4:0] OFF_SIGNAL = 5'h05;
  localparam logic [4:0] OFF_BANKSTAT = 5'h07;
  localparam logic [4:0] OFF_IDENT = 5'h08;
  localparam logic [4:0] OFF_PLL = 5'h0c;
  localparam logic [4:0] OFF_EXT = 5'h0d;
  localparam logic [4:0] OFF_RAMP = 5'h0e;

  // Slots of the 32-bit writable words inside the device
  localparam logic [2:0] W_TUNE3 = 3'h3;
  localparam logic [2:0] W_RADIO = 3'h4;
  localparam logic [2:0] W_SIGNAL = 3'h5;
  localparam logic [2:0] W_PLL = 3'h6;
  localparam logic [2:0] W_EXT = 3'h7;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_TUNE3 = 32'h03001200;
  localparam logic [31:0] RST_RADIO = 32'h00100000;
  localparam logic [31:0] RST_SIGNAL = 32'h24000000;
  localparam logic [31:0] RST_PLL = 32'h05000200;
  localparam int BIT_RX_SEN = 21;
  localparam int BIT_TX_LEVEL = 20;
  localparam int BIT_MEAS_OFF = 18;
  localparam int THR_LSB = 26;
  localparam int THR_W = 4;
  localparam int SETTLE_LSB = 24;
  localparam int SETTLE_W = 3;
  localparam int BIT_COMPAT = 9;
  localparam int BIT_BANK = 7;
  localparam logic [31:0] DEFAULT_IDENT = 32'h000000a5;  // Arbitrary value

  // ----------------------------------------------------------------
  // Initialisation words
  // ----------------------------------------------------------------
  localparam logic [31:0] INIT_TUNE0 = 32'h404b01e2;
  localparam logic [31:0] INIT_TUNE1 = 32'hc04b0000;
  localparam logic [31:0] INIT_TUNE2 = 32'hd0fc8c02;
  localparam logic [31:0] INIT_TUNE3 = 32'h99003941;
  localparam logic [31:0] INIT_RADIO_NORMAL = 32'hd99e860b;
  localparam logic [31:0] INIT_RADIO_CARRIER = 32'hd99e8621;
  localparam logic [31:0] INIT_SIGNAL = 32'h24067fa6;
  localparam logic [31:0] INIT_PLL_LONG = 32'h05731200;
  localparam logic [31:0] INIT_PLL_SHORT = 32'h00731200;
  localparam logic [31:0] INIT_EXT = 32'h0080b436;
  localparam logic [87:0] INIT_RAMP = 88'hffef7df208082082041041;

  // ----------------------------------------------------------------
  // Serial commands and framing
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [7:0] CMD_WRITE_BASE = 8'h20;
  localparam logic [7:0] CMD_TOGGLE = 8'h50;
  localparam logic [7:0] TOGGLE_KEY = 8'h53;
  localparam logic [3:0] WORD_BYTES = 4'h4;
  localparam logic [3:0] RAMP_BYTES = 4'hb;
  localparam logic [3:0] ONE_BYTE = 4'h1;
  localparam int PCLK_HZ = 10_000_000;
  localparam int SCK_MAX_HZ = 8_000_000;
  // Two cycles per half period so the device's edge detect settles
  localparam int SCK_HALF_MIN = (PCLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
  localparam logic [1:0] SCK_HALF_CYC = (SCK_HALF_MIN < 2) ? 2'h2 : 2'(SCK_HALF_MIN);
  localparam logic [1:0] CSN_GAP_CYC = 2'h2;

  // ----------------------------------------------------------------
  // Host register map and sequence steps
  // ----------------------------------------------------------------
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam int CTRL_START = 0;
  localparam int CTRL_CARRIER = 1;
  localparam int CTRL_SHORT_PLL = 2;
  localparam logic [3:0] STEP_PROBE = 4'h0;
  localparam logic [3:0] STEP_ENTER = 4'h1;
  localparam logic [3:0] STEP_CONFIRM_IN = 4'h2;
  localparam logic [3:0] STEP_LEAVE = 4'hc;
  localparam logic [3:0] STEP_CONFIRM_OUT = 4'hd;

  typedef struct packed {
    logic [6:0]  nbits;
    logic [95:0] tx;
  } scrb_frame_t;

  function automatic logic [2:0] cmd_op(input logic [7:0] cmd);
    return cmd[7:5];
  endfunction

  // Command byte first, then data bytes least significant first
  function automatic scrb_frame_t make_frame(input logic [7:0] cmd,
                                             input logic [87:0] data,
                                             input logic [3:0] nbytes);
    scrb_frame_t f;
    f.tx = {cmd, 88'h0};
    for (int i = 0; i < 11; i++) begin
      f.tx[87 - 8 * i -: 8] = data[8 * i +: 8];
    end
    f.nbits = {nbytes + 4'h1, 3'h0};
    return f;
  endfunction

endpackage

// ### core/scrb_if.sv
// Serial link between the host sequencer and the configuration bank.
// The data-out line of the device is pulled high while not driven.
`timescale 1ns/100ps
`default_nettype none
interface scrb_if;
  logic csn_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oen;
  logic miso;

  assign miso = miso_oen ? 1'b1 : miso_o;

  modport dev (input csn_n, input sck, input mosi, output miso_o, output miso_oen);
  modport host (output csn_n, output sck, output mosi, input miso);
endinterface
`default_nettype wire

// ### core/scrb_dev.sv
// Secondary configuration bank: serial slave holding the tuning words.
// Assumes link pins are synchronous to pclk and sck runs at most pclk/4.
`timescale 1ns/100ps
`default_nettype none
module scrb_dev #(
  parameter logic [31:0] IDENT = scrb_pkg::DEFAULT_IDENT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  scrb_if.dev              link,
  output logic             rx_high_sensitivity,
  output logic             tx_output_level,
  output logic [3:0]       carrier_detect_threshold,
  output logic             signal_strength_measure_off,
  output logic [2:0]       pll_settle_code,
  output logic             compat_dynamic,
  output logic             bank_indicator,
  output logic [87:0]      ramp_curve
);

  typedef struct packed {
    logic            sck_q;
    logic [2:0]      bitc;
    logic [3:0]      bytec;
    logic [7:0]      shin;
    logic [7:0]      cmd;
    logic [7:0]      shout;
    logic            miso;
    logic            bank;
    logic [7:0][31:0] word;
    logic [87:0]     ramp;
  } scrb_dev_st_t;

  scrb_dev_st_t r;
  scrb_dev_st_t next_r;
  logic [7:0]   byte_in;
  logic [3:0]   k;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic writable(input logic [4:0] a);
    return (a <= scrb_pkg::OFF_SIGNAL) || a == scrb_pkg::OFF_PLL || a == scrb_pkg::OFF_EXT;
  endfunction

  function automatic logic [2:0] slot(input logic [4:0] a);
    if (a == scrb_pkg::OFF_PLL) begin
      return scrb_pkg::W_PLL;
    end else if (a == scrb_pkg::OFF_EXT) begin
      return scrb_pkg::W_EXT;
    end
    return a[2:0];
  endfunction

  // Tuning words are write-only and read back as zero
  function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [3:0] idx,
                                           input logic bank);
    logic [31:0] v;
    v = '0;
    if (scrb_pkg::cmd_op(cmd) == scrb_pkg::OP_READ) begin
      if (cmd[4:0] == scrb_pkg::OFF_BANKSTAT) begin
        v[scrb_pkg::BIT_BANK] = bank;
      end else if (cmd[4:0] == scrb_pkg::OFF_IDENT && bank) begin
        v = IDENT;
      end
    end
    return (idx < scrb_pkg::WORD_BYTES) ? v[{idx[1:0], 3'h0} +: 8] : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    byte_in = {r.shin[6:0], link.mosi};
    k = r.bytec - 4'h1;
    next_r.sck_q = link.sck;
    if (link.csn_n) begin
      next_r.bitc = '0;
      next_r.bytec = '0;
      next_r.miso = 1'b0;
    end else if (link.sck && !r.sck_q) begin
      next_r.shin = byte_in;
      next_r.bitc = r.bitc + 3'h1;
      if (r.bitc == 3'h7) begin
        if (r.bytec != 4'hf) begin
          next_r.bytec = r.bytec + 4'h1;
        end
        if (r.bytec == 4'h0) begin
          next_r.cmd = byte_in;
          next_r.shout = read_byte(byte_in, 4'h0, r.bank);
        end else begin
          next_r.shout = read_byte(r.cmd, r.bytec, r.bank);
          if (r.cmd == scrb_pkg::CMD_TOGGLE && r.bytec == 4'h1
              && byte_in == scrb_pkg::TOGGLE_KEY) begin
            next_r.bank = !r.bank;
          end else if (r.bank && scrb_pkg::cmd_op(r.cmd) == scrb_pkg::OP_WRITE) begin
            // Bytes land as they arrive; an aborted frame leaves a partial word
            if (r.cmd[4:0] == scrb_pkg::OFF_RAMP && k < scrb_pkg::RAMP_BYTES) begin
              next_r.ramp[{k, 3'h0} +: 8] = byte_in;
            end else if (writable(r.cmd[4:0]) && k < scrb_pkg::WORD_BYTES) begin
              next_r.word[slot(r.cmd[4:0])][{k[1:0], 3'h0} +: 8] = byte_in;
            end
          end
        end
      end
    end else if (!link.sck && r.sck_q) begin
      next_r.miso = r.shout[7];
      next_r.shout = {r.shout[6:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.word[scrb_pkg::W_TUNE3] <= scrb_pkg::RST_TUNE3;
      r.word[scrb_pkg::W_RADIO] <= scrb_pkg::RST_RADIO;
      r.word[scrb_pkg::W_SIGNAL] <= scrb_pkg::RST_SIGNAL;
      r.word[scrb_pkg::W_PLL] <= scrb_pkg::RST_PLL;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.miso_o = r.miso;
  assign link.miso_oen = link.csn_n;
  assign rx_high_sensitivity = r.word[scrb_pkg::W_RADIO][scrb_pkg::BIT_RX_SEN];
  assign tx_output_level = r.word[scrb_pkg::W_RADIO][scrb_pkg::BIT_TX_LEVEL];
  assign carrier_detect_threshold =
    r.word[scrb_pkg::W_SIGNAL][scrb_pkg::THR_LSB +: scrb_pkg::THR_W];
  assign signal_strength_measure_off =
    r.word[scrb_pkg::W_SIGNAL][scrb_pkg::BIT_MEAS_OFF];
  assign pll_settle_code =
    r.word[scrb_pkg::W_PLL][scrb_pkg::SETTLE_LSB +: scrb_pkg::SETTLE_W];
  assign compat_dynamic = r.word[scrb_pkg::W_PLL][scrb_pkg::BIT_COMPAT];
  assign bank_indicator = r.bank;
  assign ramp_curve = r.ramp;

endmodule
`default_nettype wire

// ### core/scrb_host.sv
// Host sequencer: loads the secondary bank over the serial link on
// command from an APB register. Assumes a 10 MHz pclk and a device
// that follows the bank-toggle protocol.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module scrb_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  scrb_if.host             link
);

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} scrb_host_state_t;

  typedef struct packed {
    scrb_host_state_t state;
    logic [3:0]       step;
    logic             sck;
    logic             csn_n;
    logic             mosi;
    logic [1:0]       cnt;
    logic [6:0]       bitn;
    logic [6:0]       nbits;
    logic [95:0]      tx;
    logic [7:0]       rx;
    logic             opt_carrier;
    logic             opt_short;
    logic             done;
    logic             bank_err;
    logic             bank_seen;
    logic [31:0]      prdata;
  } scrb_host_st_t;

  scrb_host_st_t r;
  scrb_host_st_t next_r;
  logic          access;
  logic          bank_bit;

  // ----------------------------------------------------------------
  // Sequence table
  // ----------------------------------------------------------------
  function automatic logic [7:0] wcmd(input logic [4:0] a);
    return scrb_pkg::CMD_WRITE_BASE | {3'h0, a};
  endfunction

  function automatic scrb_pkg::scrb_frame_t wframe(input logic [4:0] a, input logic [31:0] w);
    return scrb_pkg::make_frame(wcmd(a), {56'h0, w}, scrb_pkg::WORD_BYTES);
  endfunction

  function automatic scrb_pkg::scrb_frame_t step_frame(input logic [3:0] s,
                                                       input logic carrier,
                                                       input logic short_pll);
    scrb_pkg::scrb_frame_t f;
    unique case (s)
      scrb_pkg::STEP_ENTER, scrb_pkg::STEP_LEAVE:
        f = scrb_pkg::make_frame(scrb_pkg::CMD_TOGGLE, {80'h0, scrb_pkg::TOGGLE_KEY},
                                 scrb_pkg::ONE_BYTE);
      4'h3: f = wframe(scrb_pkg::OFF_TUNE0, scrb_pkg::INIT_TUNE0);
      4'h4: f = wframe(scrb_pkg::OFF_TUNE1, scrb_pkg::INIT_TUNE1);
      4'h5: f = wframe(scrb_pkg::OFF_TUNE2, scrb_pkg::INIT_TUNE2);
      4'h6: f = wframe(scrb_pkg::OFF_TUNE3, scrb_pkg::INIT_TUNE3);
      4'h7: f = wframe(scrb_pkg::OFF_RADIO, carrier ? scrb_pkg::INIT_RADIO_CARRIER
                                                    : scrb_pkg::INIT_RADIO_NORMAL);
      4'h8: f = wframe(scrb_pkg::OFF_SIGNAL, scrb_pkg::INIT_SIGNAL);
      4'h9: f = wframe(scrb_pkg::OFF_PLL, short_pll ? scrb_pkg::INIT_PLL_SHORT
                                                    : scrb_pkg::INIT_PLL_LONG);
      4'ha: f = wframe(scrb_pkg::OFF_EXT, scrb_pkg::INIT_EXT);
      4'hb: f = scrb_pkg::make_frame(wcmd(scrb_pkg::OFF_RAMP), scrb_pkg::INIT_RAMP,
                                     scrb_pkg::RAMP_BYTES);
      // Probe and both confirmations read one byte of the bank status word
      default: f = scrb_pkg::make_frame({3'h0, scrb_pkg::OFF_BANKSTAT}, 88'h0,
                                        scrb_pkg::ONE_BYTE);
    endcase
    return f;
  endfunction

  function automatic scrb_host_st_t launch(input scrb_host_st_t s, input logic [3:0] idx);
    scrb_host_st_t o;
    scrb_pkg::scrb_frame_t f;
    o = s;
    f = step_frame(idx, s.opt_carrier, s.opt_short);
    o.step = idx;
    o.tx = f.tx;
    o.nbits = f.nbits;
    o.bitn = '0;
    o.cnt = '0;
    o.sck = 1'b0;
    o.csn_n = 1'b0;
    o.mosi = f.tx[95];
    o.state = H_SHIFT;
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    access = psel && penable;
    bank_bit = r.rx[scrb_pkg::BIT_BANK];
    // Read data is captured in the setup cycle so the answer needs no wait
    if (psel && !penable) begin
      next_r.prdata = '0;
      if (paddr == scrb_pkg::APB_CTRL) begin
        next_r.prdata = {29'h0, r.opt_short, r.opt_carrier, 1'b0};
      end else if (paddr == scrb_pkg::APB_STATUS) begin
        next_r.prdata = {28'h0, r.bank_seen, r.bank_err, r.done, r.state != H_IDLE};
      end
    end
    unique case (r.state)
      H_IDLE: begin
        if (access && pwrite && paddr == scrb_pkg::APB_CTRL) begin
          next_r.opt_carrier = pwdata[scrb_pkg::CTRL_CARRIER];
          next_r.opt_short = pwdata[scrb_pkg::CTRL_SHORT_PLL];
          if (pwdata[scrb_pkg::CTRL_START]) begin
            next_r.done = 1'b0;
            next_r.bank_err = 1'b0;
            next_r = launch(next_r, scrb_pkg::STEP_PROBE);
          end
        end
      end
      H_SHIFT: begin
        next_r.cnt = r.cnt + 2'h1;
        if (r.cnt == scrb_pkg::SCK_HALF_CYC - 2'h1) begin
          next_r.cnt = '0;
          if (!r.sck) begin
            next_r.sck = 1'b1;
            next_r.rx = {r.rx[6:0], link.miso};
          end else begin
            next_r.sck = 1'b0;
            if (r.bitn == r.nbits - 7'h1) begin
              next_r.csn_n = 1'b1;
              next_r.mosi = 1'b0;
              next_r.state = H_GAP;
            end else begin
              next_r.bitn = r.bitn + 7'h1;
              next_r.tx = {r.tx[94:0], 1'b0};
              next_r.mosi = r.tx[94];
            end
          end
        end
      end
      H_GAP: begin
        next_r.cnt = r.cnt + 2'h1;
        if (r.cnt == scrb_pkg::CSN_GAP_CYC - 2'h1) begin
          next_r.cnt = '0;
          next_r.state = H_IDLE;
          unique case (r.step)
            scrb_pkg::STEP_PROBE: begin
              next_r.bank_seen = bank_bit;
              // Already in the secondary bank: a toggle would leave it
              next_r = launch(next_r, bank_bit ? scrb_pkg::STEP_CONFIRM_IN
                                               : scrb_pkg::STEP_ENTER);
            end
            scrb_pkg::STEP_CONFIRM_IN: begin
              next_r.bank_seen = bank_bit;
              if (!bank_bit) begin
                next_r.bank_err = 1'b1;
                next_r.done = 1'b1;
              end else begin
                next_r = launch(next_r, r.step + 4'h1);
              end
            end
            scrb_pkg::STEP_CONFIRM_OUT: begin
              next_r.bank_seen = bank_bit;
              next_r.bank_err = bank_bit;
              next_r.done = 1'b1;
            end
            default: begin
              next_r = launch(next_r, r.step + 4'h1);
            end
          endcase
        end
      end
      default: begin
        next_r.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= H_IDLE;
      r.csn_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = access && paddr != scrb_pkg::APB_CTRL && paddr != scrb_pkg::APB_STATUS;
  assign link.csn_n = r.csn_n;
  assign link.sck = r.sck;
  assign link.mosi = r.mosi;

endmodule
`default_nettype wire

// ### testbench/scrb_chk.sv
// Checker for the serial link between host sequencer and bank.
// Assumes both ends run on pclk; sees the interface signals only.
`timescale 1ns/100ps
`default_nettype none
module scrb_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic csn_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oen,
  input wire logic miso
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Frame bit counter
  // ----------------------------------------------------------------
  logic       sck_q;
  logic [6:0] nrise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      nrise <= 7'h0;
    end else begin
      sck_q <= sck;
      if (csn_n)
        nrise <= 7'h0;
      else if (sck && !sck_q)
        nrise <= nrise + 7'h1;
    end
  end

  logic whole_bytes;
  assign whole_bytes = (nrise[2:0] == 3'h0) && (nrise != 7'h0);

  sequence s_high_half;
    sck ##1 sck ##1 !sck;
  endsequence
  sequence s_low_half;
    !sck ##1 !sck;
  endsequence

  a_sck_high_half: assert property ($rose(sck) |-> s_high_half)
    else $error("sck high phase not two cycles");
  a_sck_low_half: assert property ($fell(sck) |-> s_low_half)
    else $error("sck low phase shorter than two cycles");
  a_sck_idle_low: assert property (csn_n |-> !sck)
    else $error("sck moves outside a frame");
  a_oen_follows_csn: assert property (miso_oen == csn_n)
    else $error("data-out enable differs from frame select");
  a_miso_pullup: assert property (miso_oen |-> miso)
    else $error("released data-out line not high");
  a_mosi_hold_high: assert property (sck |-> $stable(mosi))
    else $error("host data changed while sck high");
  a_miso_hold_high: assert property ((sck && !csn_n) |-> $stable(miso_o))
    else $error("device data changed while sck high");
  a_frame_whole_bytes: assert property ($rose(csn_n) |-> whole_bytes)
    else $error("frame ended inside a byte");
  a_csn_gap_two: assert property ($rose(csn_n) |=> csn_n)
    else $error("frame select gap shorter than two cycles");
endmodule
`default_nettype wire

// ### testbench/secondary_config_register_bank_bench.sv
// Self-checking bench: host and bank joined by the link interface.
// Assumes 10 MHz pclk; APB master and all value expectations live here; link timing checks live in scrb_chk.
`timescale 1ns/100ps
`default_nettype none
module secondary_config_register_bank_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_sen, tx_lvl, moff, compat, bank, err, saw_bank;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  thr;
  logic [2:0]  settle;
  logic [87:0] ramp;
  int          n_fail, checks_done, rnd;
  // Write-only words are only visible inside the bank
  logic [7:0][31:0] dev_word;
  assign dev_word = u_scrb_dev.r.word;

  scrb_if u_scrb_if ();
  scrb_dev u_scrb_dev (.pclk(pclk), .presetn(presetn), .link(u_scrb_if),
    .rx_high_sensitivity(rx_sen), .tx_output_level(tx_lvl),
    .carrier_detect_threshold(thr), .signal_strength_measure_off(moff),
    .pll_settle_code(settle), .compat_dynamic(compat), .bank_indicator(bank),
    .ramp_curve(ramp));
  scrb_host u_scrb_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_scrb_if));
  scrb_chk u_scrb_chk (.pclk(pclk), .presetn(presetn), .csn_n(u_scrb_if.csn_n),
    .sck(u_scrb_if.sck), .mosi(u_scrb_if.mosi), .miso_o(u_scrb_if.miso_o),
    .miso_oen(u_scrb_if.miso_oen), .miso(u_scrb_if.miso));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Sticky: bank entry is only visible mid-sequence
  always @(posedge pclk) if (bank === 1'b1) saw_bank <= 1'b1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] exp_fields(input logic c, input logic s);
    logic [31:0] w4, wc;
    w4 = c ? scrb_pkg::INIT_RADIO_CARRIER : scrb_pkg::INIT_RADIO_NORMAL;
    wc = s ? scrb_pkg::INIT_PLL_SHORT : scrb_pkg::INIT_PLL_LONG;
    return {w4[21], w4[20], scrb_pkg::INIT_SIGNAL[29:26], scrb_pkg::INIT_SIGNAL[18],
            wc[26:24], wc[9]};
  endfunction

  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [87:0] seen, input logic [87:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Idle cycle first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      final_report();
    end
  endtask

  task automatic run(input logic c, input logic s);
    int n;
    saw_bank = 1'b0;
    apb(1'b1, scrb_pkg::APB_CTRL, {29'h0, s, c, 1'b1});
    apb(1'b0, scrb_pkg::APB_STATUS, 32'h0);
    chk(rd[1:0], 2'b01);
    // Start while busy must not change the options in flight
    apb(1'b1, scrb_pkg::APB_CTRL, {29'h0, ~s, ~c, 1'b1});
    n = 0;
    do begin
      apb(1'b0, scrb_pkg::APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      n_fail++;
      final_report();
    end
    chk(rd[3:0], 4'b0010);
    chk(saw_bank, 1'b1);
    chk({rx_sen, tx_lvl, thr, moff, settle, compat}, exp_fields(c, s));
    chk(ramp, scrb_pkg::INIT_RAMP);
    chk(bank, 1'b0);
    chk(dev_word[0], scrb_pkg::INIT_TUNE0);
    chk(dev_word[1], scrb_pkg::INIT_TUNE1);
    chk(dev_word[2], scrb_pkg::INIT_TUNE2);
    chk(dev_word[scrb_pkg::W_TUNE3], scrb_pkg::INIT_TUNE3);
    rd = c ? scrb_pkg::INIT_RADIO_CARRIER : scrb_pkg::INIT_RADIO_NORMAL;
    chk(dev_word[scrb_pkg::W_RADIO], rd);
    chk(dev_word[scrb_pkg::W_SIGNAL], scrb_pkg::INIT_SIGNAL);
    rd = s ? scrb_pkg::INIT_PLL_SHORT : scrb_pkg::INIT_PLL_LONG;
    chk(dev_word[scrb_pkg::W_PLL], rd);
    chk(dev_word[scrb_pkg::W_EXT], scrb_pkg::INIT_EXT);
    // Options written while busy must have been ignored
    apb(1'b0, scrb_pkg::APB_CTRL, 32'h0);
    chk(rd, {29'h0, s, c, 1'b0});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    saw_bank = 1'b0;
    n_fail = 0;
    checks_done = 0;
    rnd = $urandom(32'h53e7d1a8);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({rx_sen, tx_lvl}, 2'b01);
    chk({thr, moff}, 5'b10010);
    chk({settle, compat}, 4'b1011);
    chk(bank, 1'b0);
    chk(dev_word[scrb_pkg::W_TUNE3], scrb_pkg::RST_TUNE3);
    rnd = $urandom;
    apb(1'b1, 12'h008, rnd);
    chk(err, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rd}, 33'h100000000);
    apb(1'b1, scrb_pkg::APB_STATUS, 32'hf);
    apb(1'b0, scrb_pkg::APB_STATUS, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rnd = $urandom;
      if (i < 2) run(i[0], i[0]);
      else run(rnd[0], rnd[1]);
    end
    final_report();
  end
endmodule
`default_nettype wire
